// ===== hw/nvc_cfg.svh
// constants of the nonvolatile configuration programmer
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
// ****************************************
// register offsets
// ****************************************
`define NVC_ADDR_STATUS 7'h70
`define NVC_ADDR_HS 7'h71
`define NVC_ADDR_LS 7'h72
`define NVC_ADDR_STARTUP 7'h73
`define NVC_ADDR_CORE 7'h74
`define NVC_ADDR_CRC 7'h75
// ****************************************
// field positions
// ****************************************
`define NVC_STAT_PERMIT_BIT 0
`define NVC_STAT_ERR_BIT 1
`define NVC_STAT_CNT_LSB 2
`define NVC_FORCED_NORMAL_SELECT_BIT 3
// ****************************************
// reset and preset values
// ****************************************
`define NVC_PRESET_HS 8'h00
`define NVC_PRESET_LS 8'h00
`define NVC_PRESET_STARTUP 8'h00
`define NVC_PRESET_CORE 8'h08
`define NVC_HIGH_VOLTAGE_IO_PRESENT 8'hff
`define NVC_PERMIT_RESET 1'h1
`define NVC_CNT_MAX 6'h3f
// ****************************************
// crc parameters
// ****************************************
`define NVC_CRC_POLY 8'h2f
`define NVC_CRC_INIT 8'hff
`define NVC_CRC_XOR 8'hff
// ****************************************
// timing
// ****************************************
`define NVC_CLK_PERIOD_NS 20
`define NVC_BURN_TIME_NS 10000
`define NVC_BURN_CYCLES \
  ((`NVC_BURN_TIME_NS + `NVC_CLK_PERIOD_NS - 1) / `NVC_CLK_PERIOD_NS)
`endif

// ===== hw/nvc_crc8.sv
// one byte step of the non-reflected crc used for confirmation
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_crc8 import nvc_pkg::*; (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ `NVC_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end
endmodule : nvc_crc8

// ===== hw/nvc_pkg.sv
// types of the nonvolatile configuration programmer
package nvc_pkg;
  typedef enum logic [1:0] {
    NVC_IDLE = 2'b00,
    NVC_CHECK = 2'b01,
    NVC_BURN = 2'b10
  } nvc_state_t;
endpackage : nvc_pkg

// ===== hw/nvc_top.sv
// nonvolatile configuration programmer with staging, crc commit and burn
// Function
// - the four cells sit at consecutive addresses 0x71 to 0x74.
// - configuration bits of absent high-voltage pins read and stage as 0.
// - programming is refused unless the program permit flag is 1.
// - the permit flag is 1 as shipped and clears when programming ends.
// - a factory restore sets permit, loads presets and issues a reset.
// - burning starts as soon as the written crc is found valid.
// - a wrong crc aborts the attempt and leaves the cells unchanged.
// - a successful programming cycle ends with a system reset.
// - cell addresses read the old contents until programming succeeds.
// - after programming, writes to the cells are ignored until permitted.
// - the crc is 8 bit, poly 0x2f, init 0xff, xor 0xff, low byte first.
// - an address not written during staging counts as zero in the crc.
// - a six bit write counter counts programs and restores, saturating.
// - a read-only error flag shows a fault seen while programming.
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_top import nvc_pkg::*; (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic FACTORY_RESTORE,
  input wire logic PROG_FAULT,
  output logic SYS_RESET_REQ,
  output logic BUSY,
  output logic FORCED_NORMAL,
  output logic [7:0] CFG_HS,
  output logic [7:0] CFG_LS,
  output logic [7:0] CFG_STARTUP,
  output logic [7:0] CFG_CORE
);
  localparam logic [7:0] PRESET [4] = '{`NVC_PRESET_HS, `NVC_PRESET_LS,
    `NVC_PRESET_STARTUP, `NVC_PRESET_CORE};
  localparam logic [7:0] MASK [4] = '{`NVC_HIGH_VOLTAGE_IO_PRESENT, `NVC_HIGH_VOLTAGE_IO_PRESENT,
    8'hff, 8'hff};
  localparam logic [8:0] BURN_LAST = 9'(`NVC_BURN_CYCLES - 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] rest_sync_reg;
  logic [1:0] fault_sync_reg;
  logic restore_pulse;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rest_sync_reg <= 3'h0;
      fault_sync_reg <= 2'h0;
    end else if (CE) begin
      rest_sync_reg <= {rest_sync_reg[1:0], FACTORY_RESTORE};
      fault_sync_reg <= {fault_sync_reg[0], PROG_FAULT};
    end
  end
  assign restore_pulse = rest_sync_reg[1] & ~rest_sync_reg[2];

  // ****************************************
  // state
  // ****************************************
  nvc_state_t state_reg, state_next;
  logic [7:0] cell_reg [4];
  logic [7:0] cell_next [4];
  logic [7:0] stage_reg [4];
  logic [7:0] stage_next [4];
  logic [7:0] confirm_reg, confirm_next;
  logic [7:0] crc_reg, crc_next;
  logic [1:0] idx_reg, idx_next;
  logic [8:0] burn_reg, burn_next;
  logic permit_reg, permit_next;
  logic err_reg, err_next;
  logic fault_reg, fault_next;
  logic [5:0] cnt_reg, cnt_next;
  logic rst_req_reg, rst_req_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] crc_step;
  logic [6:0] offs;
  logic cell_addr;
  logic crc_ok;

  nvc_crc8 u_crc (
    .crc_in(crc_reg),
    .data_in(stage_reg[idx_reg]),
    .crc_out(crc_step)
  );

  assign offs = REG_ADDR - `NVC_ADDR_HS;
  assign cell_addr = (REG_ADDR >= `NVC_ADDR_HS) &&
    (REG_ADDR <= `NVC_ADDR_CORE);
  assign crc_ok = (crc_step ^ `NVC_CRC_XOR) == confirm_reg;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cell_next = cell_reg;
    stage_next = stage_reg;
    confirm_next = confirm_reg;
    crc_next = crc_reg;
    idx_next = idx_reg;
    burn_next = burn_reg;
    permit_next = permit_reg;
    err_next = err_reg;
    fault_next = fault_reg;
    cnt_next = cnt_reg;
    rst_req_next = 1'b0;
    rdata_next = rdata_reg;
    if (restore_pulse) begin
      cell_next = PRESET;
      permit_next = 1'b1;
      rst_req_next = 1'b1;
      err_next = 1'b0;
      if (cnt_reg != `NVC_CNT_MAX) begin
        cnt_next = cnt_reg + 6'h1;
      end
      stage_next = '{default: 8'h00};
      state_next = NVC_IDLE;
    end else begin
      case (state_reg)
        NVC_IDLE: begin
          if (REG_WR && permit_reg) begin
            if (cell_addr) begin
              stage_next[offs[1:0]] = REG_WDATA & MASK[offs[1:0]];
            end else if (REG_ADDR == `NVC_ADDR_CRC) begin
              confirm_next = REG_WDATA;
              crc_next = `NVC_CRC_INIT;
              idx_next = 2'h0;
              state_next = NVC_CHECK;
            end
          end
        end
        NVC_CHECK: begin
          crc_next = crc_step;
          idx_next = idx_reg + 2'h1;
          if (idx_reg == 2'h3) begin
            if (crc_ok) begin
              burn_next = BURN_LAST;
              fault_next = 1'b0;
              state_next = NVC_BURN;
            end else begin
              stage_next = '{default: 8'h00};
              state_next = NVC_IDLE;
            end
          end
        end
        NVC_BURN: begin
          fault_next = fault_reg | fault_sync_reg[1];
          burn_next = burn_reg - 9'h1;
          if (burn_reg == 9'h0) begin
            if (fault_next) begin
              err_next = 1'b1;
            end else begin
              cell_next = stage_reg;
              err_next = 1'b0;
              rst_req_next = 1'b1;
            end
            permit_next = 1'b0;
            if (cnt_reg != `NVC_CNT_MAX) begin
              cnt_next = cnt_reg + 6'h1;
            end
            stage_next = '{default: 8'h00};
            state_next = NVC_IDLE;
          end
        end
        default: begin
          state_next = NVC_IDLE;
        end
      endcase
    end
    if (REG_RD) begin
      if (REG_ADDR == `NVC_ADDR_STATUS) begin
        rdata_next = {cnt_reg, err_reg, permit_reg};
      end else if (cell_addr) begin
        rdata_next = cell_reg[offs[1:0]];
      end else if (REG_ADDR == `NVC_ADDR_CRC) begin
        rdata_next = confirm_reg;
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= NVC_IDLE;
      cell_reg <= PRESET;
      stage_reg <= '{default: 8'h00};
      confirm_reg <= 8'h00;
      crc_reg <= `NVC_CRC_INIT;
      idx_reg <= 2'h0;
      burn_reg <= 9'h0;
      permit_reg <= `NVC_PERMIT_RESET;
      err_reg <= 1'b0;
      fault_reg <= 1'b0;
      cnt_reg <= 6'h00;
      rst_req_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else if (CE) begin
      state_reg <= state_next;
      cell_reg <= cell_next;
      stage_reg <= stage_next;
      confirm_reg <= confirm_next;
      crc_reg <= crc_next;
      idx_reg <= idx_next;
      burn_reg <= burn_next;
      permit_reg <= permit_next;
      err_reg <= err_next;
      fault_reg <= fault_next;
      cnt_reg <= cnt_next;
      rst_req_reg <= rst_req_next;
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign SYS_RESET_REQ = rst_req_reg;
  assign BUSY = state_reg != NVC_IDLE;
  assign CFG_HS = cell_reg[0];
  assign CFG_LS = cell_reg[1];
  assign CFG_STARTUP = cell_reg[2];
  assign CFG_CORE = cell_reg[3];
  assign FORCED_NORMAL = cell_reg[3][`NVC_FORCED_NORMAL_SELECT_BIT];

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);

  refuse_commit_a: assert property (
    CE && !restore_pulse && state_reg == NVC_IDLE && !permit_reg && REG_WR
      |=> state_reg == NVC_IDLE)
    else $error("commit taken without permit");
  permit_clear_a: assert property (
    CE && !restore_pulse && state_reg == NVC_BURN && burn_reg == 9'h0
      |=> !permit_reg && state_reg == NVC_IDLE)
    else $error("permit not cleared after programming");
  restore_a: assert property (
    CE && restore_pulse |=> permit_reg && SYS_RESET_REQ && FORCED_NORMAL)
    else $error("factory restore incomplete");
  crc_good_a: assert property (
    CE && !restore_pulse && state_reg == NVC_CHECK && idx_reg == 2'h3
      && crc_ok |=> state_reg == NVC_BURN && burn_reg == BURN_LAST)
    else $error("valid crc did not start burn");
  crc_bad_a: assert property (
    CE && !restore_pulse && state_reg == NVC_CHECK && idx_reg == 2'h3
      && !crc_ok |=> state_reg == NVC_IDLE && $stable(CFG_CORE)
      && stage_reg[0] == 8'h00)
    else $error("bad crc not aborted");
  reset_cause_a: assert property (
    $rose(SYS_RESET_REQ) |-> $past(restore_pulse)
      || ($past(state_reg) == NVC_BURN && !err_reg))
    else $error("system reset without cause");
  cell_read_a: assert property (
    CE && REG_RD && REG_ADDR == `NVC_ADDR_HS |=> REG_RDATA == $past(CFG_HS))
    else $error("cell read mismatch");
  stage_mask_a: assert property (
    CE && !restore_pulse && state_reg == NVC_IDLE && permit_reg && REG_WR
      && REG_ADDR == `NVC_ADDR_HS
      |=> stage_reg[0] == ($past(REG_WDATA) & `NVC_HIGH_VOLTAGE_IO_PRESENT))
    else $error("absent pin bit staged");
  count_sat_a: assert property (
    cnt_reg == `NVC_CNT_MAX |=> cnt_reg == `NVC_CNT_MAX)
    else $error("write counter wrapped");
endmodule : nvc_top

// ===== verification/nvc_host.sv
// host model that drives the register port and works out the crc
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_host import nvc_pkg::*; (
  input wire logic CLK,
  output logic [6:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  output logic REG_RD
);
  logic [7:0] exp_q[$];
  initial begin
    REG_ADDR = 7'h00;
    REG_WDATA = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
  end
  // one access, then the idle bus shows the inverse of the last value
  task automatic acc(input logic [6:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge CLK);
    #1;
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = w;
    REG_RD = !w;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask : acc
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    acc(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 1'b0);
  endtask : rd
  function automatic logic [7:0] crc4(input logic [7:0] v [4]);
    logic [7:0] c;
    c = `NVC_CRC_INIT;
    for (int i = 0; i < 4; i++) begin
      c = c ^ v[i];
      for (int j = 0; j < 8; j++) begin
        c = c[7] ? ((c << 1) ^ `NVC_CRC_POLY) : (c << 1);
      end
    end
    return c ^ `NVC_CRC_XOR;
  endfunction : crc4
  // zero bytes are left unwritten
  task automatic stage(input logic [7:0] v [4]);
    for (int i = 0; i < 4; i++) begin
      if (v[i] != 8'h00) begin
        wr(7'h71 + 7'(i), v[i]);
      end
    end
  endtask : stage
  task automatic commit(input logic [7:0] v [4], input logic [7:0] bad);
    wr(`NVC_ADDR_CRC, crc4(v) ^ bad);
  endtask : commit
endmodule : nvc_host

// ===== verification/nvc_top_test.sv
// self-checking bench of the nonvolatile configuration programmer
`timescale 1ns/1ps
`include "nvc_cfg.svh"
module nvc_top_test import nvc_pkg::*;;
  logic clk, rst_b, fres, fault, srq, busy, fnm, wr, rd, rd1, rd2;
  logic [6:0] addr;
  logic [7:0] wd, rdat, hs, ls, su, core;
  logic [7:0] b [4];
  logic [7:0] cells [4];
  int fails = 0, tests_run = 0, pulses = 0, cyc = 0, seed;
  nvc_host u_nvc_host (.CLK(clk), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd));
  nvc_top u_nvc_top (.CLK(clk), .RST_B(rst_b), .CE(1'b1),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdat), .FACTORY_RESTORE(fres), .PROG_FAULT(fault),
    .SYS_RESET_REQ(srq), .BUSY(busy), .FORCED_NORMAL(fnm),
    .CFG_HS(hs), .CFG_LS(ls), .CFG_STARTUP(su), .CFG_CORE(core));
  // ****************************************
  // compare, report and watch
  // ****************************************
  task automatic cmp_byte(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_byte
  task automatic cmp_cnt(string n, int e, int g);
    tests_run++;
    if (g != e) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask : cmp_cnt
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    rd1 <= rd;
    rd2 <= rd1;
    pulses <= pulses + int'(srq === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  // read data is settled well before the next read is taken
  always @(negedge clk) begin
    if (rd2 === 1'b1) begin
      cmp_byte("rdata", u_nvc_host.exp_q.pop_front(), rdat);
    end
  end
  task automatic chk_cells();
    for (int i = 0; i < 4; i++) begin
      u_nvc_host.rd(7'h71 + 7'(i), cells[i]);
    end
    cmp_byte("hs", cells[0], hs);
    cmp_byte("ls", cells[1], ls);
    cmp_byte("startup", cells[2], su);
    cmp_byte("core", cells[3], core);
    cmp_byte("fnm", {7'h00, cells[3][3]}, {7'h00, fnm});
  endtask : chk_cells
  task automatic new_data();
    for (int i = 0; i < 4; i++) begin
      b[i] = (i == 1) ? 8'h00 : 8'($random(seed));
    end
  endtask : new_data
  task automatic drive_pin(ref logic p, input logic v);
    @(posedge clk);
    #1;
    p = v;
  endtask : drive_pin
  task automatic wait_idle();
    for (int i = 0; i < 700 && busy !== 1'b0; i++) begin
      @(negedge clk);
    end
    repeat (2) @(negedge clk);
    cmp_byte("busy", 8'h00, {7'h00, busy});
  endtask : wait_idle
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 41;
    rst_b = 1'b0;
    fres = 1'b0;
    fault = 1'b0;
    cells = '{8'h00, 8'h00, 8'h00, 8'h08};
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    u_nvc_host.rd(`NVC_ADDR_STATUS, 8'h01);
    u_nvc_host.rd(7'h10, 8'h00);
    chk_cells();
    new_data();
    u_nvc_host.stage(b);
    u_nvc_host.rd(7'h71, cells[0]);
    u_nvc_host.commit(b, 8'h01);
    cmp_byte("busy", 8'h01, {7'h00, busy});
    wait_idle();
    cmp_cnt("pulses", 0, pulses);
    chk_cells();
    new_data();
    u_nvc_host.stage(b);
    u_nvc_host.commit(b, 8'h00);
    cmp_byte("busy", 8'h01, {7'h00, busy});
    wait_idle();
    cmp_cnt("pulses", 1, pulses);
    cells = b;
    chk_cells();
    u_nvc_host.rd(`NVC_ADDR_STATUS, 8'h04);
    u_nvc_host.wr(7'h71, ~b[0]);
    u_nvc_host.commit(b, 8'h00);
    cmp_byte("busy", 8'h00, {7'h00, busy});
    wait_idle();
    cmp_cnt("pulses", 1, pulses);
    chk_cells();
    drive_pin(fres, 1'b1);
    repeat (10) @(negedge clk);
    drive_pin(fres, 1'b0);
    cmp_cnt("pulses", 2, pulses);
    cells = '{8'h00, 8'h00, 8'h00, 8'h08};
    chk_cells();
    u_nvc_host.rd(`NVC_ADDR_STATUS, 8'h09);
    new_data();
    u_nvc_host.stage(b);
    u_nvc_host.commit(b, 8'h00);
    repeat (20) @(negedge clk);
    drive_pin(fault, 1'b1);
    wait_idle();
    drive_pin(fault, 1'b0);
    cmp_cnt("pulses", 2, pulses);
    chk_cells();
    u_nvc_host.rd(`NVC_ADDR_STATUS, 8'h0e);
    repeat (4) @(negedge clk);
    end_sim();
  end
endmodule : nvc_top_test
